//--- src/drive_sys_params.sv
// Functional notes
// - Switching frequency setting accepted from 4 kHz to 32 kHz.
// - Current loop rate setting accepted from 1 kHz to 16 kHz.
// - Position loop rate only 0.1, 0.5, 1 or 2 kHz.
// - Switching and current loop rates come in discrete doubling steps such as 4, 8, 16, 32 kHz.
// - Peek address written over sub-indices 0 to 3; any address readable.
// - Peek format codes -4,-2,-1 signed and 1,2,4 unsigned widths.
// - Unlock keys select test mode 0, test mode 1, user password.
// - Load monitor reports four usages as percent, 100 is full load.
// - Cause bits: 0 watchdog, 1 software, 2 power-on reset.
// - Firmware update reset sets bit 4 and the software bit too.
// - Bit 8 flags two flash wait states programmed.
// - Any write to the reset cause word sets bit 12.
// - Writing 0xAFFE resets the system only while test mode 1 is unlocked.
// - New baud rate takes effect after the answer at the old rate.
// - Serial link baud rate defaults to 115200.
// - Version readout has four read-only sub-indices 0 to 3.
`timescale 1ns/1ps
module drive_sys_params (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [7:0]  par_id,
  input  wire logic [7:0]  par_sub,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_ack,
  output logic             par_err,
  input  wire logic        drive_running,
  output logic      [31:0] mem_addr,
  output logic             mem_rd_req,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_rd_valid,
  input  wire logic [7:0]  load_sys_stack,
  input  wire logic [7:0]  load_user_stack,
  input  wire logic [7:0]  load_proc_sig,
  input  wire logic [7:0]  load_mem_alloc,
  input  wire logic        cause_watchdog,
  input  wire logic        cause_software,
  input  wire logic        cause_power_on,
  input  wire logic        cause_update,
  input  wire logic        flash_ws2,
  output logic             sw_reset_req,
  output logic             test_mode0,
  output logic             test_mode1,
  output logic             user_unlocked,
  output logic      [31:0] pwm_freq_hz,
  output logic      [31:0] cur_loop_hz,
  output logic      [31:0] pos_loop_hz,
  input  wire logic        serial_resp_done,
  output logic      [31:0] serial_baud
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {PH_IDLE, PH_PEEK} phase_type;

  typedef struct packed {
    phase_type                          phase;
    logic [31:0]                        pwm_hz;
    logic [31:0]                        cur_hz;
    logic [31:0]                        pos_hz;
    logic [31:0]                        peek_addr;
    logic [31:0]                        peek_fmt;
    logic [31:0]                        unlock;
    logic [31:0]                        baud_active;
    logic [31:0]                        baud_pending;
    logic                               baud_switch;
    logic [3:0]                         resp_open;
    logic [3:0]                         baud_wait;
    logic [drive_sys_pkg::CAUSE_W-1:0]  cause;
    logic                               caught;
    logic [31:0]                        rdata;
    logic                               ack;
    logic                               err;
    logic                               mem_req;
    logic                               swrst;
  } state_type;

  localparam state_type STATE_RST = '{
    phase:        PH_IDLE,
    pwm_hz:       drive_sys_pkg::PWM_RST,
    cur_hz:       drive_sys_pkg::CUR_RST,
    pos_hz:       drive_sys_pkg::POS_RST,
    peek_addr:    32'h0000_0000,
    peek_fmt:     drive_sys_pkg::FMT_U32,
    unlock:       32'h0000_0000,
    baud_active:  drive_sys_pkg::BAUD_RST,
    baud_pending: drive_sys_pkg::BAUD_RST,
    baud_switch:  1'b0,
    resp_open:    4'h0,
    baud_wait:    4'h0,
    cause:        '0,
    caught:       1'b0,
    rdata:        32'h0000_0000,
    ack:          1'b0,
    err:          1'b0,
    mem_req:      1'b0,
    swrst:        1'b0
  };

  state_type   s_r;
  state_type   s_nxt;
  logic [31:0] peek_value;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic pwm_ok(input logic [31:0] hz);
    pwm_ok = (hz == drive_sys_pkg::HZ_4K) || (hz == drive_sys_pkg::HZ_8K) ||
             (hz == drive_sys_pkg::HZ_16K) || (hz == drive_sys_pkg::HZ_32K);
  endfunction

  function automatic logic cur_ok(input logic [31:0] hz);
    cur_ok = (hz == drive_sys_pkg::HZ_1K) || (hz == drive_sys_pkg::HZ_2K) ||
             (hz == drive_sys_pkg::HZ_4K) || (hz == drive_sys_pkg::HZ_8K) ||
             (hz == drive_sys_pkg::HZ_16K);
  endfunction

  function automatic logic pos_ok(input logic [31:0] hz);
    pos_ok = (hz == drive_sys_pkg::HZ_100) || (hz == drive_sys_pkg::HZ_500) ||
             (hz == drive_sys_pkg::HZ_1K) || (hz == drive_sys_pkg::HZ_2K);
  endfunction

  function automatic logic fmt_ok(input logic [31:0] code);
    fmt_ok = (code == drive_sys_pkg::FMT_S32) || (code == drive_sys_pkg::FMT_S16) ||
             (code == drive_sys_pkg::FMT_S8) || (code == drive_sys_pkg::FMT_U8) ||
             (code == drive_sys_pkg::FMT_U16) || (code == drive_sys_pkg::FMT_U32);
  endfunction

  // Percentages above full load are shown as full load.
  function automatic logic [31:0] pct(input logic [7:0] raw);
    pct = (raw > drive_sys_pkg::LOAD_FULL) ? {24'h00_0000, drive_sys_pkg::LOAD_FULL}
                                           : {24'h00_0000, raw};
  endfunction

  // ----------------------------------------------------------------
  // Peeked word formatting
  // ----------------------------------------------------------------
  peek_formatter u_fmt (
    .word  (mem_rdata),
    .fmt   (s_r.peek_fmt),
    .value (peek_value)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Requests are taken only in PH_IDLE; a request during a peek is ignored.
  always_comb begin
    logic [31:0] p;
    logic [31:0] c;
    logic [31:0] q;
    s_nxt         = s_r;
    p             = s_r.pwm_hz;
    c             = s_r.cur_hz;
    q             = s_r.pos_hz;
    s_nxt.ack     = 1'b0;
    s_nxt.err     = 1'b0;
    s_nxt.mem_req = 1'b0;
    s_nxt.swrst   = 1'b0;

    // Reset causes are caught once, on the first edge after release.
    if (!s_r.caught) begin
      s_nxt.caught                          = 1'b1;
      s_nxt.cause[drive_sys_pkg::CB_WATCHDOG] = cause_watchdog;
      s_nxt.cause[drive_sys_pkg::CB_SOFTWARE] = cause_software | cause_update;
      s_nxt.cause[drive_sys_pkg::CB_POWER_ON] = cause_power_on;
      s_nxt.cause[drive_sys_pkg::CB_UPDATE]   = cause_update;
      s_nxt.cause[drive_sys_pkg::CB_FLASH_WS2] = flash_ws2;
    end

    // Answers handed to the link and not yet fully sent. A stray done pulse
    // after reset must not wrap the count; more than 15 in flight is unsupported.
    s_nxt.resp_open = s_r.resp_open + {3'h0, s_r.ack};
    if (serial_resp_done && s_nxt.resp_open != 4'h0) begin
      s_nxt.resp_open = s_nxt.resp_open - 4'h1;
    end
    // The link keeps the old rate until every answer queued ahead of the
    // rate write, and the write's own answer, has left the wire.
    if (serial_resp_done && s_r.baud_switch) begin
      s_nxt.baud_wait = s_r.baud_wait - 4'h1;
      if (s_r.baud_wait <= 4'h1) begin
        s_nxt.baud_active = s_r.baud_pending;
        s_nxt.baud_switch = 1'b0;
      end
    end

    case (s_r.phase)
      PH_PEEK: begin
        if (mem_rd_valid) begin
          s_nxt.rdata = peek_value;
          s_nxt.ack   = 1'b1;
          s_nxt.phase = PH_IDLE;
        end
      end
      PH_IDLE: begin
        if (par_wr) begin
          s_nxt.ack = 1'b1;
          case (par_id)
            drive_sys_pkg::ID_LOOP_RATES: begin
              case (par_sub)
                8'h00:   p = par_wdata;
                8'h01:   c = par_wdata;
                8'h02:   q = par_wdata;
                default: p = 32'h0000_0000;
              endcase
              // Rates are only taken while stopped and in proper order.
              if (!drive_running && pwm_ok(p) && cur_ok(c) && pos_ok(q)
                  && (p >= c) && (c >= q)) begin
                s_nxt.pwm_hz = p;
                s_nxt.cur_hz = c;
                s_nxt.pos_hz = q;
              end else begin
                s_nxt.err = 1'b1;
              end
            end
            drive_sys_pkg::ID_PEEK: begin
              if (par_sub <= drive_sys_pkg::SUB_LAST_QUAD) begin
                s_nxt.peek_addr[{par_sub[1:0], 3'b000} +: 8] = par_wdata[7:0];
              end else if (par_sub == drive_sys_pkg::SUB_PEEK_FMT && fmt_ok(par_wdata)) begin
                s_nxt.peek_fmt = par_wdata;
              end else begin
                s_nxt.err = 1'b1;
              end
            end
            drive_sys_pkg::ID_UNLOCK: begin
              s_nxt.unlock = par_wdata;
            end
            drive_sys_pkg::ID_RESET_CAUSE: begin
              s_nxt.cause[drive_sys_pkg::CB_WRITTEN] = 1'b1;
              if (par_wdata == drive_sys_pkg::SW_RESET_VALUE
                  && s_r.unlock == drive_sys_pkg::KEY_TEST1) begin
                s_nxt.swrst = 1'b1;
              end
            end
            drive_sys_pkg::ID_SERIAL_RATE: begin
              // A zero rate could never be left again, so it is refused.
              if (par_wdata != 32'h0000_0000) begin
                s_nxt.baud_pending = par_wdata;
                s_nxt.baud_switch  = 1'b1;
                s_nxt.baud_wait    = s_nxt.resp_open + 4'h1;
              end else begin
                s_nxt.err = 1'b1;
              end
            end
            default: s_nxt.err = 1'b1;
          endcase
        end else if (par_rd) begin
          s_nxt.ack   = 1'b1;
          s_nxt.rdata = 32'h0000_0000;
          case (par_id)
            drive_sys_pkg::ID_VERSION: begin
              case (par_sub)
                8'h00:   s_nxt.rdata = drive_sys_pkg::VER_SOFTWARE;
                8'h01:   s_nxt.rdata = drive_sys_pkg::VER_PARAM_SET;
                8'h02:   s_nxt.rdata = drive_sys_pkg::VER_TELEGRAM;
                8'h03:   s_nxt.rdata = drive_sys_pkg::VER_FIELDBUS;
                default: s_nxt.err   = 1'b1;
              endcase
            end
            drive_sys_pkg::ID_LOOP_RATES: begin
              case (par_sub)
                8'h00:   s_nxt.rdata = s_r.pwm_hz;
                8'h01:   s_nxt.rdata = s_r.cur_hz;
                8'h02:   s_nxt.rdata = s_r.pos_hz;
                default: s_nxt.err   = 1'b1;
              endcase
            end
            drive_sys_pkg::ID_PEEK: begin
              if (par_sub <= drive_sys_pkg::SUB_LAST_QUAD) begin
                s_nxt.rdata = {24'h00_0000, s_r.peek_addr[{par_sub[1:0], 3'b000} +: 8]};
              end else if (par_sub == drive_sys_pkg::SUB_PEEK_FMT) begin
                s_nxt.rdata = s_r.peek_fmt;
              end else if (par_sub == drive_sys_pkg::SUB_PEEK_VALUE) begin
                // The answer waits for the memory; no ack until it returns.
                s_nxt.ack     = 1'b0;
                s_nxt.mem_req = 1'b1;
                s_nxt.phase   = PH_PEEK;
              end else begin
                s_nxt.err = 1'b1;
              end
            end
            drive_sys_pkg::ID_UNLOCK: s_nxt.rdata = s_r.unlock;
            drive_sys_pkg::ID_LOAD: begin
              case (par_sub)
                8'h00:   s_nxt.rdata = pct(load_sys_stack);
                8'h01:   s_nxt.rdata = pct(load_user_stack);
                8'h02:   s_nxt.rdata = pct(load_proc_sig);
                8'h03:   s_nxt.rdata = pct(load_mem_alloc);
                default: s_nxt.err   = 1'b1;
              endcase
            end
            drive_sys_pkg::ID_RESET_CAUSE: begin
              s_nxt.rdata = {{(32 - drive_sys_pkg::CAUSE_W){1'b0}}, s_r.cause};
            end
            drive_sys_pkg::ID_SERIAL_RATE: begin
              s_nxt.rdata = s_r.baud_switch ? s_r.baud_pending : s_r.baud_active;
            end
            default: s_nxt.err = 1'b1;
          endcase
        end
      end
      default: s_nxt.phase = PH_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register, except the unlock flags, which are decoded from the unlock field.
  assign par_rdata     = s_r.rdata;
  assign par_ack       = s_r.ack;
  assign par_err       = s_r.err;
  assign mem_addr      = s_r.peek_addr;
  assign mem_rd_req    = s_r.mem_req;
  assign sw_reset_req  = s_r.swrst;
  assign test_mode0    = (s_r.unlock == drive_sys_pkg::KEY_TEST0);
  assign test_mode1    = (s_r.unlock == drive_sys_pkg::KEY_TEST1);
  assign user_unlocked = (s_r.unlock == drive_sys_pkg::KEY_USER);
  assign pwm_freq_hz   = s_r.pwm_hz;
  assign cur_loop_hz   = s_r.cur_hz;
  assign pos_loop_hz   = s_r.pos_hz;
  assign serial_baud   = s_r.baud_active;

endmodule

//--- src/drive_sys_pkg.sv
// Constants shared by the drive system parameter block and its helpers.
package drive_sys_pkg;

  // ----------------------------------------------------------------
  // Parameter identifiers seen on the parameter access port
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_VERSION     = 8'h01;
  localparam logic [7:0] ID_LOOP_RATES  = 8'h03;
  localparam logic [7:0] ID_PEEK        = 8'h04;
  localparam logic [7:0] ID_UNLOCK      = 8'h05;
  localparam logic [7:0] ID_LOAD        = 8'h06;
  localparam logic [7:0] ID_RESET_CAUSE = 8'h07;
  localparam logic [7:0] ID_SERIAL_RATE = 8'h08;

  // Sub-indices of the memory peek parameter: format and value beyond the four address bytes, and the last address byte.
  localparam logic [7:0] SUB_PEEK_FMT   = 8'h04;
  localparam logic [7:0] SUB_PEEK_VALUE = 8'h05;
  localparam logic [7:0] SUB_LAST_QUAD  = 8'h03;
  // Version readout values (arbitrary values).
  localparam logic [31:0] VER_SOFTWARE  = 32'h0000_0100;
  localparam logic [31:0] VER_PARAM_SET = 32'h0000_0001;
  localparam logic [31:0] VER_TELEGRAM  = 32'h0000_0001;
  localparam logic [31:0] VER_FIELDBUS  = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Settings, their reset values and the reset cause layout
  // ----------------------------------------------------------------
  // Loop rates in Hz.
  localparam logic [31:0] HZ_100   = 32'd100;
  localparam logic [31:0] HZ_500   = 32'd500;
  localparam logic [31:0] HZ_1K    = 32'd1000;
  localparam logic [31:0] HZ_2K    = 32'd2000;
  localparam logic [31:0] HZ_4K    = 32'd4000;
  localparam logic [31:0] HZ_8K    = 32'd8000;
  localparam logic [31:0] HZ_16K   = 32'd16000;
  localparam logic [31:0] HZ_32K   = 32'd32000;
  localparam logic [31:0] PWM_RST  = 32'd16000;
  localparam logic [31:0] CUR_RST  = 32'd8000;
  localparam logic [31:0] POS_RST  = 32'd1000;
  // Memory peek output format codes.
  localparam logic [31:0] FMT_S32 = 32'hFFFF_FFFC;
  localparam logic [31:0] FMT_S16 = 32'hFFFF_FFFE;
  localparam logic [31:0] FMT_S8  = 32'hFFFF_FFFF;
  localparam logic [31:0] FMT_U8  = 32'h0000_0001;
  localparam logic [31:0] FMT_U16 = 32'h0000_0002;
  localparam logic [31:0] FMT_U32 = 32'h0000_0004;
  // Unlock key words.
  localparam logic [31:0] KEY_TEST0 = 32'd91196599;
  localparam logic [31:0] KEY_TEST1 = 32'd32168421;
  localparam logic [31:0] KEY_USER  = 32'd9441707;
  // Reset cause word layout and guarded reset value.
  localparam int          CAUSE_W        = 13;
  localparam int          CB_WATCHDOG    = 0;
  localparam int          CB_SOFTWARE    = 1;
  localparam int          CB_POWER_ON    = 2;
  localparam int          CB_UPDATE      = 4;
  localparam int          CB_FLASH_WS2   = 8;
  localparam int          CB_WRITTEN     = 12;
  localparam logic [31:0] SW_RESET_VALUE = 32'h0000_AFFE;
  // Load monitor full scale and serial link default rate.
  localparam logic [7:0]  LOAD_FULL = 8'd100;
  localparam logic [31:0] BAUD_RST  = 32'd115200;
endpackage

//--- src/peek_formatter.sv
// Sign or zero extension of a peeked memory word by its format code.
`timescale 1ns/1ps
module peek_formatter (
  input  wire logic [31:0] word,
  input  wire logic [31:0] fmt,
  output logic      [31:0] value
);

  // ----------------------------------------------------------------
  // Format selection
  // ----------------------------------------------------------------
  // Codes are checked on write and reset loads FMT_U32, so an unknown code here only comes before reset.
  always_comb begin
    case (fmt)
      drive_sys_pkg::FMT_S8:  value = {{24{word[7]}}, word[7:0]};
      drive_sys_pkg::FMT_S16: value = {{16{word[15]}}, word[15:0]};
      drive_sys_pkg::FMT_U8:  value = {24'h00_0000, word[7:0]};
      drive_sys_pkg::FMT_U16: value = {16'h0000, word[15:0]};
      default:                value = word;
    endcase
  end

endmodule

//--- bench/drive_sys_params_sva.sv
// Port-level assertions for the drive system parameter block.
`timescale 1ns/1ps
module drive_sys_params_sva (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        par_wr,
  input wire logic        par_rd,
  input wire logic [7:0]  par_id,
  input wire logic [7:0]  par_sub,
  input wire logic [31:0] par_wdata,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic        drive_running,
  input wire logic        mem_rd_req,
  input wire logic        sw_reset_req,
  input wire logic        test_mode1,
  input wire logic [31:0] cur_loop_hz,
  input wire logic        serial_resp_done,
  input wire logic [31:0] serial_baud
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic pw_r;
  logic go;
  logic wr;
  logic pk;
  logic kick;
  // Requests during a peek wait are ignored, so they never count as taken.
  assign go   = !pw_r && (par_wr || par_rd);
  assign wr   = go && par_wr;
  assign pk   = go && !par_wr && par_id == drive_sys_pkg::ID_PEEK
                && par_sub == drive_sys_pkg::SUB_PEEK_VALUE;
  assign kick = wr && par_id == drive_sys_pkg::ID_RESET_CAUSE
                && par_wdata == drive_sys_pkg::SW_RESET_VALUE && test_mode1;
  // The wait flag drops after the answer cycle, a safe over-estimate.
  always_ff @(posedge clock) begin
    if (sys_rst) pw_r <= 1'b0;
    else if (pk) pw_r <= 1'b1;
    else if (par_ack) pw_r <= 1'b0;
  end
  a_err_has_ack: assert property (par_err |-> par_ack)
    else $error("error flag without answer");
  a_req_answered: assert property (go && !pk |=> par_ack)
    else $error("request not answered next cycle");
  a_version_ro: assert property (wr && par_id == drive_sys_pkg::ID_VERSION |=> par_err)
    else $error("version write not refused");
  a_rate_frozen: assert property (wr && drive_running
    && par_id == drive_sys_pkg::ID_LOOP_RATES |=> par_err && $stable(cur_loop_hz))
    else $error("loop rate changed while running");
  a_reset_guarded: assert property (sw_reset_req |-> $past(kick))
    else $error("software reset without key");
  a_reset_fires: assert property (kick |=> sw_reset_req)
    else $error("software reset not requested");
  a_peek_fetch: assert property (pk |=> mem_rd_req)
    else $error("peek did not fetch memory");
  a_baud_late: assert property ($changed(serial_baud) |-> $past(serial_resp_done))
    else $error("baud changed before answer sent");
  c_soft_reset: cover property (sw_reset_req);
  c_peek: cover property (pk ##1 mem_rd_req);
  c_refused: cover property (par_err);
endmodule

//--- bench/drive_sys_partner.sv
// Memory and serial link model on the far side of the parameter block.
`timescale 1ns/1ps
module drive_sys_partner (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [31:0] mem_addr,
  input  wire logic        mem_rd_req,
  output logic      [31:0] mem_rdata,
  output logic             mem_rd_valid,
  input  wire logic        par_ack,
  output logic             serial_resp_done
);
  int         wait_n = -1;
  logic [2:0] done_sh = 3'h0;
  initial {mem_rdata, mem_rd_valid, serial_resp_done} = '0;
  // Any address answers after one to eight idle cycles; between answers the
  // data shows the inverse of its last value, so stale data is never trusted.
  always @(posedge clock) begin
    mem_rd_valid <= 1'b0;
    mem_rdata    <= ~mem_rdata;
    if (sys_rst) wait_n <= -1;
    else if (mem_rd_req) wait_n <= mem_addr[2:0];
    else if (wait_n >= 0) wait_n <= wait_n - 1;
    if (!sys_rst && !mem_rd_req && wait_n == 0) begin
      mem_rd_valid <= 1'b1;
      mem_rdata    <= ~mem_addr ^ 32'h0F0F_7070;
    end
  end
  // Each answer is fully sent four cycles after it is handed over.
  always @(posedge clock) begin
    done_sh          <= {done_sh[1:0], par_ack && !sys_rst};
    serial_resp_done <= done_sh[2];
  end
endmodule

//--- bench/test_drive_sys_params.sv
// Self-checking bench for the drive system parameter block.
`timescale 1ns/1ps
module test_drive_sys_params;
  logic        clock, sys_rst, par_wr, par_rd, par_ack, par_err, drive_running, er, sr;
  logic        mem_rd_req, mem_rd_valid, cause_watchdog, cause_software, cause_power_on;
  logic        cause_update, flash_ws2, sw_reset_req, test_mode0, test_mode1;
  logic        user_unlocked, serial_resp_done;
  logic [7:0]  par_id, par_sub, load_sys_stack, load_user_stack, load_proc_sig, load_mem_alloc;
  logic [31:0] par_wdata, par_rdata, mem_addr, mem_rdata, pwm_freq_hz, cur_loop_hz;
  logic [31:0] pos_loop_hz, serial_baud, rd, seed, v, cf, e[3], t[3], tbl[10], fx[7];
  int          miscompares, num_checks, n, i, j, k;
  drive_sys_params  dut (.*);
  drive_sys_partner mem (.*);
  // Free-running clock, 5 ns period.
  always #2.5 clock = ~clock;
  // Expectation helpers: random source, peek formatting, legal rate index.
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] fm(logic [31:0] a, logic [31:0] f);
    logic [31:0] w;
    w = ~a ^ 32'h0F0F_7070;
    case (f)
      drive_sys_pkg::FMT_S16: return {{16{w[15]}}, w[15:0]};
      drive_sys_pkg::FMT_U16: return {16'h0000, w[15:0]};
      drive_sys_pkg::FMT_S8:  return {{24{w[7]}}, w[7:0]};
      drive_sys_pkg::FMT_U8:  return {24'h00_0000, w[7:0]};
      default:                return w;
    endcase
  endfunction
  function automatic bit ok(int s, int k);
    return s == 0 ? k inside {[4:7]} : s == 1 ? k inside {[2:6]} : s == 2 && k < 4;
  endfunction
  // Comparison, verdict, one parameter access and reset.
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(logic w, logic [7:0] id, logic [7:0] s, logic [31:0] d);
    @(posedge clock);
    par_wr    <= w;
    par_rd    <= !w;
    par_id    <= id;
    par_sub   <= s;
    par_wdata <= d;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      par_wr <= 1'b0;
      par_rd <= 1'b0;
      #1;
      if (par_ack === 1'b1) break;
    end
    rd = par_rdata;
    er = par_err;
    sr = sw_reset_req;
    if (n == 200) begin
      miscompares++;
      test_done;
    end
  endtask
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
  endtask
  // Main sequence.
  initial begin
    {clock, par_wr, par_rd, drive_running, par_id, par_sub, par_wdata} = '0;
    {load_sys_stack, load_user_stack, load_proc_sig, load_mem_alloc} = '0;
    {cause_watchdog, cause_software, cause_power_on, cause_update, flash_ws2} = 5'b10011;
    {miscompares, num_checks} = '0;
    seed = 32'h421C;
    tbl = '{drive_sys_pkg::HZ_100, drive_sys_pkg::HZ_500, drive_sys_pkg::HZ_1K,
            drive_sys_pkg::HZ_2K, drive_sys_pkg::HZ_4K, drive_sys_pkg::HZ_8K,
            drive_sys_pkg::HZ_16K, drive_sys_pkg::HZ_32K, 32'h0000_0BB8, 32'h0000_FA00};
    fx = '{drive_sys_pkg::FMT_S32, drive_sys_pkg::FMT_S16, drive_sys_pkg::FMT_S8, 32'h3,
           drive_sys_pkg::FMT_U8, drive_sys_pkg::FMT_U16, drive_sys_pkg::FMT_U32};
    rst;
    acc(1'b0, drive_sys_pkg::ID_RESET_CAUSE, 8'h00, 32'h0);
    chk("cause_straps", rd, 32'h0000_0113);
    chk("baud_default", serial_baud, 32'h0001_C200);
    for (i = 0; i < 4; i++) begin
      acc(1'b0, drive_sys_pkg::ID_VERSION, 8'(i), 32'h0);
      chk("version", rd, i == 0 ? drive_sys_pkg::VER_SOFTWARE : i == 1 ?
          drive_sys_pkg::VER_PARAM_SET : i == 2 ? drive_sys_pkg::VER_TELEGRAM :
          drive_sys_pkg::VER_FIELDBUS);
    end
    acc(1'b1, drive_sys_pkg::ID_VERSION, 8'h00, seed);
    chk("version_refused", 32'(er), 32'h1);
    // Load limits 100, 101, 0, 255, then random loads.
    for (j = 0; j < 3; j++) begin
      seed = xs(seed);
      cf = j == 0 ? 32'h6465_00FF : seed;
      @(posedge clock);
      {load_sys_stack, load_user_stack, load_proc_sig, load_mem_alloc} <= cf;
      for (i = 0; i < 4; i++) begin
        acc(1'b0, drive_sys_pkg::ID_LOAD, 8'(i), 32'h0);
        v = (cf >> (24 - 8 * i)) & 32'hFF;
        chk("load_pct", rd, v > 100 ? 32'h64 : v);
      end
    end
    // Random rate writes, some while running, out of order or off the steps.
    e = '{drive_sys_pkg::PWM_RST, drive_sys_pkg::CUR_RST, drive_sys_pkg::POS_RST};
    for (i = 0; i < 80; i++) begin
      seed = xs(seed);
      k = seed[7:0] % 10;
      j = seed[9:8];
      @(posedge clock);
      drive_running <= seed[12:10] == 3'h0;
      acc(1'b1, drive_sys_pkg::ID_LOOP_RATES, 8'(j), tbl[k]);
      t = e;
      if (j < 3) t[j] = tbl[k];
      v = 32'(ok(j, k) && !drive_running && t[0] >= t[1] && t[1] >= t[2]);
      if (v[0]) e = t;
      chk("rate_refused", 32'(er), 32'(!v[0]));
      chk("pwm_hz", pwm_freq_hz, e[0]);
      chk("cur_hz", cur_loop_hz, e[1]);
      chk("pos_hz", pos_loop_hz, e[2]);
    end
    // Every peek format at fresh addresses; the bad code keeps the last one.
    for (i = 0; i < 7; i++) begin
      seed = xs(seed);
      for (j = 3; j >= 0; j--) acc(1'b1, drive_sys_pkg::ID_PEEK, 8'(j), 32'(seed[8*j +: 8]));
      chk("peek_addr", mem_addr, seed);
      acc(1'b1, drive_sys_pkg::ID_PEEK, drive_sys_pkg::SUB_PEEK_FMT, fx[i]);
      chk("fmt_refused", 32'(er), 32'(i == 3));
      if (i != 3) cf = fx[i];
      acc(1'b0, drive_sys_pkg::ID_PEEK, drive_sys_pkg::SUB_PEEK_VALUE, 32'h0);
      chk("peek_value", rd, fm(seed, cf));
    end
    // Each key, then the guarded reset value.
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = k == 0 ? drive_sys_pkg::KEY_TEST0 : k == 1 ? drive_sys_pkg::KEY_TEST1 :
          k == 2 ? drive_sys_pkg::KEY_USER : seed;
      acc(1'b1, drive_sys_pkg::ID_UNLOCK, 8'h00, v);
      acc(1'b0, drive_sys_pkg::ID_UNLOCK, 8'h00, 32'h0);
      chk("unlock_word", rd, v);
      chk("unlock_modes", {29'h0, test_mode0, test_mode1, user_unlocked}, 32'(4 >> k));
      acc(1'b1, drive_sys_pkg::ID_RESET_CAUSE, 8'h00, drive_sys_pkg::SW_RESET_VALUE);
      chk("soft_reset", 32'(sr), 32'(k == 1));
    end
    acc(1'b0, drive_sys_pkg::ID_RESET_CAUSE, 8'h00, 32'h0);
    chk("cause_written", rd, 32'h0000_1113);
    // Baud change takes effect only once the answer is out.
    acc(1'b1, drive_sys_pkg::ID_SERIAL_RATE, 8'h00, 32'h0);
    chk("baud_zero", 32'(er), 32'h1);
    acc(1'b1, drive_sys_pkg::ID_SERIAL_RATE, 8'h00, 32'h0000_E100);
    chk("baud_old", serial_baud, 32'h0001_C200);
    acc(1'b0, drive_sys_pkg::ID_SERIAL_RATE, 8'h00, 32'h0);
    chk("baud_read", rd, 32'h0000_E100);
    repeat (6) @(posedge clock);
    #1;
    chk("baud_new", serial_baud, 32'h0000_E100);
    // Mid-run reset with power-on and software straps.
    @(posedge clock);
    {cause_watchdog, cause_software, cause_power_on, cause_update, flash_ws2} <= 5'b01100;
    rst;
    acc(1'b0, drive_sys_pkg::ID_RESET_CAUSE, 8'h00, 32'h0);
    chk("cause_sw_pwr", rd, 32'h0000_0006);
    chk("baud_reset", serial_baud, 32'h0001_C200);
    chk("unlock_reset", {29'h0, test_mode0, test_mode1, user_unlocked}, 32'h0);
    test_done;
  end
endmodule
bind drive_sys_params drive_sys_params_sva chk_i (.*);
